// file: core/capture_defs.svh
// Constants for the input-capture timer: selects, encodings, reset values
`ifndef CAPTURE_DEFS_SVH
`define CAPTURE_DEFS_SVH
`define CNT_W          16
`define CNT_RESET      16'h0000
`define EDGE_RISE      2'h0
`define EDGE_FALL      2'h1
`define EDGE_BOTH      2'h2
`define SRC_F1         3'h0
`define SRC_F2         3'h1
`define SRC_F4         3'h2
`define SRC_F8         3'h3
`define SRC_F32        3'h4
`define SRC_EXT        3'h5
`define SRC_FAST       3'h6
`define SRC_FASTDIV    3'h7
`define FILT_MATCHES   2'h3
`define PRESCALE_W     5
`endif

// file: core/capture_pkg.sv
// Types shared by the input-capture timer
package capture_pkg;
  typedef logic [15:0] count_t;  // Counter and register width
  typedef logic [1:0]  edge_t;   // Edge select field
  typedef logic [2:0]  src_t;    // Count source select
endpackage : capture_pkg

// file: core/capture_filter.sv
// Two-stage synchroniser plus optional three-sample digital filter
`timescale 1ns/1ps
`include "capture_defs.svh"
module capture_filter (
  input  wire logic clk_i,      // Timer clock
  input  wire logic reset_i,    // Async reset, active high
  input  wire logic enable_i,   // Clock enable
  input  wire logic filter_en_i,// Filter on
  input  wire logic sample_i,   // Sampling strobe for filter
  input  wire logic pin_i,      // Raw asynchronous pin
  output logic      level_o     // Cleaned level
);
  logic       sync_a;   // First stage, read only by sync_b
  logic       sync_b;   // Second stage
  logic [1:0] run;      // Matching samples so far
  logic       filt;     // Filtered level
  wire        differ = (sync_b != filt);  // New level seen
  wire        done   = (run == `FILT_MATCHES - 2'h1);  // Third match
  // Synchroniser
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else if (enable_i) begin
      sync_a <= pin_i;
      sync_b <= sync_a;
    end
  end
  // Filter: accept level after three consecutive matches
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      run  <= 2'h0;
      filt <= 1'b0;
    end else if (enable_i && sample_i) begin
      if (!differ) begin
        run <= 2'h0;
      end else if (done) begin
        filt <= sync_b;
        run  <= 2'h0;
      end else begin
        run <= run + 2'h1;
      end
    end
  end
  assign level_o = filter_en_i ? filt : sync_b;  // Filter bypass when off
endmodule : capture_filter

// file: core/timer_input_capture.sv
// Sixteen-bit up-counter with four input-capture general registers
// Contract
// - Valid pin edge copies counter into register
// - Each pin independently enabled for capture
// - Register A may trigger from slow oscillator
// - Count source: five dividers, two fast, external
// - Increment per source event; free-run wraps
// - Clear on A match when clear-select set
// - Run bit high starts counting
// - Run bit low holds counter value
// - Capture raises interrupt request pulse
// - Overflow raises interrupt request pulse
// - Counter value always readable
// - Software write loads counter
// - Edge selectable rising, falling or both
// - Clear on A match or on capture
// - Buffer and filter individually selectable
// - Buffering moves A/B into C/D on capture
// - Filter needs three matching samples
// - Edge code 00 rise, 01 fall, 10 both
// - Source select 0 oscillator, 1 pin
`timescale 1ns/1ps
`include "capture_defs.svh"
module timer_input_capture (
  input  wire logic              clk_i,             // Timer clock 100 MHz
  input  wire logic              reset_i,           // Async reset, active high
  input  wire logic              enable_i,          // Clock enable
  input  wire logic              count_run_bit_i,   // Counting enabled
  input  wire capture_pkg::src_t count_src_i,       // Count source select
  input  wire logic              counter_clear_select_i, // 1: clear on A match
  input  wire logic              clear_on_capture_i,// With clear-select 0: clear on capture
  input  wire logic [3:0]        capture_en_i,      // Per-pin capture enable
  input  wire logic [7:0]        edge_sel_i,        // Two bits per register, A low
  input  wire logic              capture_source_select_a_i, // 0 oscillator, 1 pin
  input  wire logic              buffer_enable_c_i, // C buffers A
  input  wire logic              buffer_enable_d_i, // D buffers B
  input  wire logic [3:0]        filter_en_i,       // Per-input filter enable
  input  wire logic [3:0]        capture_input_pin_i, // Capture pins A..D
  input  wire logic              slow_oscillator_trigger_i, // Internal trigger
  input  wire logic              external_count_clock_pin_i, // External count clock
  input  wire logic              fast_oscillator_clock_i,    // Fast osc tick
  input  wire logic              fast_oscillator_divided_i,  // Divided fast tick
  input  wire logic              counter_wr_i,      // Load counter strobe
  input  wire capture_pkg::count_t counter_wdata_i, // Load value
  input  wire capture_pkg::count_t general_reg_a_wdata_i, // Compare value load
  input  wire logic              general_reg_a_wr_i, // Load register A
  output capture_pkg::count_t    up_counter_o,      // Counter value
  output capture_pkg::count_t    general_reg_a_o,   // Register A
  output capture_pkg::count_t    general_reg_b_o,   // Register B
  output capture_pkg::count_t    general_reg_c_o,   // Register C
  output capture_pkg::count_t    general_reg_d_o,   // Register D
  output logic [3:0]             capture_irq_o,     // Capture pulse per register
  output logic                   overflow_irq_o     // Overflow pulse
);
  import capture_pkg::*;

  count_t                  up_counter;       // Running count
  count_t                  capture_general_reg [4];  // Registers A..D
  logic [`PRESCALE_W-1:0]  prescale;         // Divider for system sources
  logic [3:0]              level_prev;       // Previous filtered levels
  logic                    ext_prev;         // Previous external clock level
  logic                    fast_prev;        // Previous fast tick
  logic                    fdiv_prev;        // Previous divided fast tick
  logic [2:0]              fast_sync;        // Fast osc sync chain
  logic [2:0]              fdiv_sync;        // Divided fast sync chain
  logic [1:0]              ext_sync;         // External clock sync
  logic [3:0]              capture_irq;      // Capture pulses
  logic                    overflow_irq;     // Overflow pulse
  logic [3:0]              level;            // Filtered input levels
  logic [3:0]              raw_in;           // Selected trigger inputs
  logic [3:0]              hit;              // Capture event per register
  logic                    tick;             // Count source event
  count_t                  next_counter;     // Counter next value

  // Register A picks oscillator or pin
  assign raw_in[0] = capture_source_select_a_i ? capture_input_pin_i[0]
                                               : slow_oscillator_trigger_i;
  assign raw_in[3:1] = capture_input_pin_i[3:1];

  // Per-input synchroniser and filter, edge detection
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_in
      wire [1:0] es   = edge_sel_i[2*g+1:2*g];
      wire       rise = level[g] & ~level_prev[g];
      wire       fall = ~level[g] & level_prev[g];
      capture_filter u_filt (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .enable_i    (enable_i),
        .filter_en_i (filter_en_i[g]),
        .sample_i    (1'b1),
        .pin_i       (raw_in[g]),
        .level_o     (level[g])
      );
      // Edge code decode
      assign hit[g] = capture_en_i[g] &&
                      ((es == `EDGE_RISE && rise) ||
                       (es == `EDGE_FALL && fall) ||
                       (es == `EDGE_BOTH && (rise || fall)));
    end
  endgenerate

  // Divider taps for system sources
  wire div_wrap = 1'b1;
  wire tap_f2  = prescale[0];
  wire tap_f4  = &prescale[1:0];
  wire tap_f8  = &prescale[2:0];
  wire tap_f32 = &prescale[4:0];
  wire ext_edge  = ext_sync[1] & ~ext_prev;
  wire fast_edge = fast_sync[2] & ~fast_prev;
  wire fdiv_edge = fdiv_sync[2] & ~fdiv_prev;

  // Count source select
  always_comb begin
    case (count_src_i)
      `SRC_F1:      tick = div_wrap;
      `SRC_F2:      tick = tap_f2;
      `SRC_F4:      tick = tap_f4;
      `SRC_F8:      tick = tap_f8;
      `SRC_F32:     tick = tap_f32;
      `SRC_EXT:     tick = ext_edge;
      `SRC_FAST:    tick = fast_edge;
      `SRC_FASTDIV: tick = fdiv_edge;
      default:      tick = 1'b0;
    endcase
  end

  // Clear and overflow decisions
  wire counting   = count_run_bit_i & tick;
  wire at_max     = (up_counter == 16'hffff);
  wire match_a    = counter_clear_select_i &&
                    (up_counter == capture_general_reg[0]);
  wire any_hit    = |hit;
  wire cap_clear  = !counter_clear_select_i && clear_on_capture_i && any_hit;
  wire overflow   = counting && at_max && !match_a;

  // Counter next value; capture clear over write over count
  always_comb begin
    if (cap_clear) begin
      next_counter = `CNT_RESET;
    end else if (counter_wr_i) begin
      next_counter = counter_wdata_i;
    end else if (counting && match_a) begin
      next_counter = `CNT_RESET;
    end else if (counting) begin
      next_counter = up_counter + 16'h0001;
    end else begin
      next_counter = up_counter;
    end
  end

  // Counter register
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      up_counter <= `CNT_RESET;
    end else if (enable_i) begin
      up_counter <= next_counter;
    end
  end

  // Prescaler runs freely for system-clock dividers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      prescale <= '0;
    end else if (enable_i) begin
      prescale <= prescale + 5'h01;
    end
  end

  // Synchronise external and oscillator clocks
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ext_sync  <= 2'h0;
      fast_sync <= 3'h0;
      fdiv_sync <= 3'h0;
      ext_prev  <= 1'b0;
      fast_prev <= 1'b0;
      fdiv_prev <= 1'b0;
    end else if (enable_i) begin
      ext_sync  <= {ext_sync[0], external_count_clock_pin_i};
      fast_sync <= {fast_sync[1:0], fast_oscillator_clock_i};
      fdiv_sync <= {fdiv_sync[1:0], fast_oscillator_divided_i};
      ext_prev  <= ext_sync[1];
      fast_prev <= fast_sync[2];
      fdiv_prev <= fdiv_sync[2];
    end
  end

  // Previous levels for edge detect
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      level_prev <= 4'h0;
    end else if (enable_i) begin
      level_prev <= level;
    end
  end

  // Captures take the pre-write counter; buffering shifts A/B into C/D
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < 4; i++) begin
        capture_general_reg[i] <= `CNT_RESET;
      end
    end else if (enable_i) begin
      if (hit[0]) begin
        capture_general_reg[0] <= up_counter;
      end else if (general_reg_a_wr_i) begin
        capture_general_reg[0] <= general_reg_a_wdata_i;
      end
      if (hit[1]) begin
        capture_general_reg[1] <= up_counter;
      end
      if (buffer_enable_c_i) begin
        if (hit[0]) begin
          capture_general_reg[2] <= capture_general_reg[0];
        end
      end else if (hit[2]) begin
        capture_general_reg[2] <= up_counter;
      end
      if (buffer_enable_d_i) begin
        if (hit[1]) begin
          capture_general_reg[3] <= capture_general_reg[1];
        end
      end else if (hit[3]) begin
        capture_general_reg[3] <= up_counter;
      end
    end
  end

  // Interrupt pulses
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      capture_irq  <= 4'h0;
      overflow_irq <= 1'b0;
    end else if (enable_i) begin
      capture_irq  <= hit;
      overflow_irq <= overflow;
    end
  end

  assign up_counter_o    = up_counter;
  assign general_reg_a_o = capture_general_reg[0];
  assign general_reg_b_o = capture_general_reg[1];
  assign general_reg_c_o = capture_general_reg[2];
  assign general_reg_d_o = capture_general_reg[3];
  assign capture_irq_o   = capture_irq;
  assign overflow_irq_o  = overflow_irq;

  // Checks
  chk_capture_value: assert property (@(posedge clk_i) disable iff (reset_i)
    (enable_i && hit[1]) |=> general_reg_b_o == $past(up_counter))
    else $error("register B did not capture counter");
  chk_capture_irq: assert property (@(posedge clk_i) disable iff (reset_i)
    (enable_i && hit[0]) |=> capture_irq_o[0])
    else $error("capture interrupt missing");
  chk_overflow_wrap: assert property (@(posedge clk_i) disable iff (reset_i)
    (enable_i && overflow && !counter_wr_i && !cap_clear) |=>
      (up_counter_o == 16'h0000 && overflow_irq_o))
    else $error("overflow did not wrap and flag");
  chk_stop_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    (enable_i && !count_run_bit_i && !counter_wr_i && !cap_clear) |=>
      $stable(up_counter_o))
    else $error("counter moved while stopped");
  chk_write_load: assert property (@(posedge clk_i) disable iff (reset_i)
    (enable_i && counter_wr_i && !cap_clear) |=>
      up_counter_o == $past(counter_wdata_i))
    else $error("counter write not loaded");
  chk_match_clear: assert property (@(posedge clk_i) disable iff (reset_i)
    (enable_i && counting && match_a && !counter_wr_i) |=>
      up_counter_o == 16'h0000)
    else $error("A match did not clear counter");
  chk_buffer_shift: assert property (@(posedge clk_i) disable iff (reset_i)
    (enable_i && buffer_enable_c_i && hit[0]) |=>
      general_reg_c_o == $past(capture_general_reg[0]))
    else $error("buffer did not shift A into C");
  chk_run_count: assert property (@(posedge clk_i) disable iff (reset_i)
    (enable_i && counting && !at_max && !match_a && !counter_wr_i && !cap_clear)
      |=> up_counter_o == $past(up_counter) + 16'h0001)
    else $error("counter did not increment");
  chk_capture_a_value: assert property (@(posedge clk_i) disable iff (reset_i)
    (enable_i && hit[0]) |=>
      general_reg_a_o == $past(up_counter_o))
    else $error("register A did not take pre-write counter");
  chk_capture_gate: assert property (@(posedge clk_i) disable iff (reset_i)
    (enable_i && !capture_en_i[1]) |=>
      (!capture_irq_o[1] && $stable(general_reg_b_o)))
    else $error("disabled register B still captured");
  chk_reserved_code: assert property (@(posedge clk_i) disable iff (reset_i)
    (enable_i && edge_sel_i[3:2] == 2'h3) |=>
      !capture_irq_o[1])
    else $error("reserved edge code captured");
  chk_capture_clear: assert property (@(posedge clk_i) disable iff (reset_i)
    (enable_i && cap_clear) |=>
      up_counter_o == `CNT_RESET)
    else $error("capture did not clear counter");
  chk_rise_capture: assert property (@(posedge clk_i) disable iff (reset_i)
    (enable_i && capture_en_i[1] && edge_sel_i[3:2] == `EDGE_RISE && $rose(level[1]))
      |-> hit[1])
    else $error("rising edge on B not taken");
endmodule : timer_input_capture

// file: tb/signal_source.sv
// Far-side model: capture pins, slow trigger and count clocks
`timescale 1ns/1ps
module signal_source (
  input  wire logic       clk_i,       // Timer clock
  input  wire logic       ext_run_i,   // Let external count clock run
  output logic [3:0]      pins_o,      // Capture pins A..D
  output logic            slow_trig_o, // Slow oscillator trigger
  output logic            ext_clk_o,   // External count clock
  output logic            fast_o,      // Fast oscillator tick
  output logic            fast_div_o   // Divided fast tick
);
  logic [3:0] osc = 4'h0;              // Free-running oscillator phase

  initial begin
    pins_o = 4'h0;
    slow_trig_o = 1'b0;
  end

  // On-chip oscillators run free; external clock idles low between bursts
  always @(posedge clk_i) begin
    osc <= osc + 4'h1;
    ext_clk_o <= ext_run_i ? osc[1] : 1'b0;
  end
  assign fast_o = osc[1];
  assign fast_div_o = osc[3];

  // Set one line (4 = slow trigger) to a level and hold it n cycles
  task automatic drive(input int idx, input logic v, input int n);
    @(posedge clk_i);
    if (idx == 4) slow_trig_o <= v;
    else pins_o[idx] <= v;
    repeat (n) @(posedge clk_i);
  endtask : drive
endmodule : signal_source

// file: tb/timer_input_capture_test.sv
// Self-checking bench for the input-capture timer
`timescale 1ns/1ps
module timer_input_capture_test;
  import capture_pkg::*;
  logic clk_i = 0, reset_i = 1, run = 0, clr_sel = 0, clr_cap = 0, src_a = 1;
  logic buf_c = 0, buf_d = 0, cnt_wr = 0, a_wr = 0, ext_run = 0, en = 1;
  src_t src = 3'h0;
  logic [3:0] cap_en = 4'hf, filt = 4'h0, cirq, pins;
  logic [7:0] edges = 8'h00;
  count_t wdata = 16'h0, a_wdata = 16'h0, cnt, ga, gb, gc, gd;
  logic ovf, slow, extc, fast, fdiv;
  int num_errors = 0, num_checks = 0, irqs[5] = '{0, 0, 0, 0, 0}, base, lo;
  int divs[8] = '{1, 2, 4, 8, 32, 4, 4, 16};  // Ticks per count, by source
  int ecnt[4] = '{1, 1, 2, 0};                // Captures per rise+fall, by code

  always #5 clk_i = ~clk_i;

  timer_input_capture timer_input_capture_inst (.clk_i(clk_i), .reset_i(reset_i),
    .enable_i(en), .count_run_bit_i(run), .count_src_i(src),
    .counter_clear_select_i(clr_sel), .clear_on_capture_i(clr_cap),
    .capture_en_i(cap_en), .edge_sel_i(edges), .capture_source_select_a_i(src_a),
    .buffer_enable_c_i(buf_c), .buffer_enable_d_i(buf_d), .filter_en_i(filt),
    .capture_input_pin_i(pins), .slow_oscillator_trigger_i(slow),
    .external_count_clock_pin_i(extc), .fast_oscillator_clock_i(fast),
    .fast_oscillator_divided_i(fdiv), .counter_wr_i(cnt_wr), .counter_wdata_i(wdata),
    .general_reg_a_wdata_i(a_wdata), .general_reg_a_wr_i(a_wr), .up_counter_o(cnt),
    .general_reg_a_o(ga), .general_reg_b_o(gb), .general_reg_c_o(gc),
    .general_reg_d_o(gd), .capture_irq_o(cirq), .overflow_irq_o(ovf));

  signal_source signal_source_inst (.clk_i(clk_i), .ext_run_i(ext_run), .pins_o(pins),
    .slow_trig_o(slow), .ext_clk_o(extc), .fast_o(fast), .fast_div_o(fdiv));

  // Count interrupt pulses, captures A..D then overflow
  always @(posedge clk_i) begin
    for (int k = 0; k < 4; k++) if (cirq[k] === 1'b1) irqs[k]++;
    if (ovf === 1'b1) irqs[4]++;
  end

  task automatic check(input count_t got, input count_t exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Load the halted counter with a value
  task automatic load(input count_t v);
    @(posedge clk_i);
    cnt_wr <= 1'b1;
    wdata <= v;
    @(posedge clk_i);
    cnt_wr <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : load

  // Run the counter for n ticks, then halt it
  task automatic run_for(input int n);
    @(posedge clk_i);
    run <= 1'b1;
    repeat (n) @(posedge clk_i);
    run <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : run_for

  // Hold counter at v, then give one line a rise and a fall
  task automatic pulse(input int idx, input count_t v);
    load(v);
    signal_source_inst.drive(idx, 1'b1, 5);
    signal_source_inst.drive(idx, 1'b0, 8);
  endtask : pulse

  task automatic test_basic();
    check(cnt, 16'h0000);
    check(ga | gb | gc | gd, 16'h0000);
    load(16'h1234);
    check(cnt, 16'h1234);
    run_for(10);
    check(cnt, 16'h123e);
    repeat (5) @(posedge clk_i);
    check(cnt, 16'h123e);
    run <= 1'b1;
    en <= 1'b0;
    repeat (5) @(posedge clk_i);
    check(cnt, 16'h123e);
    run <= 1'b0;
    en <= 1'b1;
    base = irqs[4];
    load(16'hffff);
    run_for(3);
    check(cnt, 16'h0002);
    check(count_t'(irqs[4] - base), 16'h0001);
    $display("test basic done");
  endtask : test_basic

  task automatic test_sources();
    for (int s = 0; s < 8; s++) begin
      src <= src_t'(s);
      ext_run <= (s == 5);
      load(16'h0000);
      run_for(64);
      lo = 64 / divs[s] - 2;
      num_checks++;
      if ($isunknown(cnt) || int'(cnt) < lo || int'(cnt) > lo + 4) begin
        num_errors++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, cnt, 64 / divs[s]);
      end
    end
    src <= 3'h0;
    ext_run <= 1'b0;
    $display("test sources done");
  endtask : test_sources

  task automatic test_clear();
    @(posedge clk_i);
    clr_sel <= 1'b1;
    a_wr <= 1'b1;
    a_wdata <= 16'h0003;
    @(posedge clk_i);
    a_wr <= 1'b0;
    base = irqs[4];
    load(16'h0000);
    run_for(8);
    check(cnt, 16'h0000);
    check(count_t'(irqs[4] - base), 16'h0000);
    clr_sel <= 1'b0;
    clr_cap <= 1'b1;
    load(16'h0050);
    run <= 1'b1;
    signal_source_inst.drive(1, 1'b1, 5);
    run <= 1'b0;
    signal_source_inst.drive(1, 1'b0, 4);
    check(gb, 16'h0053);
    check(cnt, 16'h0002);
    clr_cap <= 1'b0;
    $display("test clear done");
  endtask : test_clear

  task automatic test_capture();
    for (int c = 0; c < 4; c++) begin
      edges <= {4'h0, c[1:0], 2'h0};
      base = irqs[1];
      pulse(1, 16'h0100 + count_t'(c));
      check(count_t'(irqs[1] - base), count_t'(ecnt[c]));
      check(gb, c == 3 ? 16'h0102 : 16'h0100 + count_t'(c));
    end
    edges <= 8'h00;
    buf_c <= 1'b1;
    pulse(0, 16'h0aaa);
    pulse(0, 16'h0bbb);
    check(ga, 16'h0bbb);
    check(gc, 16'h0aaa);
    buf_c <= 1'b0;
    src_a <= 1'b0;
    pulse(0, 16'h0ccc);
    check(ga, 16'h0bbb);
    pulse(4, 16'h0ddd);
    check(ga, 16'h0ddd);
    check(count_t'(irqs[0]), 16'h0003);
    src_a <= 1'b1;
    cap_en <= 4'b1101;
    base = irqs[1];
    pulse(1, 16'h0eee);
    check(count_t'(irqs[1] - base), 16'h0000);
    check(gb, 16'h0102);
    cap_en <= 4'hf;
    pulse(2, 16'h0123);
    check(gc, 16'h0123);
    check(count_t'(irqs[2]), 16'h0001);
    buf_d <= 1'b1;
    pulse(1, 16'h0111);
    check(gb, 16'h0111);
    check(gd, 16'h0102);
    buf_d <= 1'b0;
    filt <= 4'h8;
    signal_source_inst.drive(3, 1'b1, 1);
    signal_source_inst.drive(3, 1'b0, 8);
    check(count_t'(irqs[3]), 16'h0000);
    pulse(3, 16'h0fff);
    check(gd, 16'h0fff);
    check(count_t'(irqs[3]), 16'h0001);
    $display("test capture done");
  endtask : test_capture

  // Mid-run reset clears counter and registers; a counter write loads afterwards
  task automatic test_reset();
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    check(cnt, 16'h0000);
    check(ga | gb | gc | gd, 16'h0000);
    load(16'h0007);
    check(cnt, 16'h0007);
    $display("test reset done");
  endtask : test_reset

  task automatic test_done();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // Watchdog well beyond the nine hundred or so cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    test_done();
  end

  initial begin
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    test_basic();
    test_sources();
    test_clear();
    test_capture();
    test_reset();
    test_done();
  end
endmodule : timer_input_capture_test
